// File: hw/fuc_pkg.sv
// Constants and carrier types for the float to unsigned conversion unit
package fuc_pkg;

  // ==========================================================================
  // Widths
  localparam int WORD_W = 32;
  localparam int ADDR_W = 8;
  localparam int EXP_W = 11;
  localparam int EXT_W = 4;
  localparam int NREG = 8;
  localparam int NPART = 3;

  // ==========================================================================
  // Operand layout: high word holds sign and exponent, middle word the mantissa
  localparam int SIGN_BIT = 11;
  localparam logic [EXP_W-1:0] EXP_ONES = 11'h7ff;
  localparam logic [EXP_W-1:0] EXP_BIAS = 11'h3ff;
  localparam logic [12:0] SHIFT_BASE = 13'h041e;
  localparam logic [12:0] SHIFT_MAX = 13'h0040;
  localparam int QUIET_BIT = 30;

  // ==========================================================================
  // Fixed results
  localparam logic [WORD_W-1:0] RES_POS_MAX = 32'h7fffffff;
  localparam logic [WORD_W-1:0] RES_NEG_LIM = 32'h80000000;
  localparam logic [WORD_W-1:0] RES_NAN = 32'hffffffff;
  localparam logic [WORD_W-1:0] RES_ZERO = 32'h00000000;

  // ==========================================================================
  // Instruction decode fields and base cycle count
  localparam logic [5:0] OPC_HIGH = 6'h22;
  localparam logic [1:0] OPC_ROUND = 2'h0;
  localparam logic [1:0] OPC_TRUNC = 2'h2;
  localparam logic [7:0] BASE_CYCLES = 8'h02;

  // ==========================================================================
  // Rounding modes held in the machine status word
  localparam logic [1:0] RM_NEAREST = 2'h0;
  localparam logic [1:0] RM_ZERO = 2'h1;
  localparam logic [1:0] RM_MINUS = 2'h2;
  localparam logic [1:0] RM_PLUS = 2'h3;

  // ==========================================================================
  // Condition code byte and exception field bit positions
  localparam int CC_V = 1;
  localparam int CC_Z = 2;
  localparam int CC_N = 3;
  localparam int CC_I = 4;
  localparam int EX_INX = 0;
  localparam int EX_DZ = 1;
  localparam int EX_UNF = 2;
  localparam int EX_OVF = 3;
  localparam int EX_OPERAND_ERROR_FLAG = 4;
  localparam int EX_SIGNALING_NAN_FLAG = 5;
  localparam int EX_NAN = 6;
  localparam int EX_UNORDERED_FLAG = 7;

  // ==========================================================================
  // Register map, byte addresses
  localparam logic [ADDR_W-1:0] ADR_STATUS_WORD = 8'h00;
  localparam logic [ADDR_W-1:0] ADR_COND = 8'h04;
  localparam logic [ADDR_W-1:0] ADR_EXC = 8'h08;
  localparam logic [ADDR_W-1:0] ADR_EXC_ACC = 8'h0c;
  localparam logic [ADDR_W-1:0] ADR_IRQ_STATUS = 8'h10;
  localparam logic [ADDR_W-1:0] ADR_IRQ_CLEAR = 8'h14;
  localparam logic [ADDR_W-1:0] ADR_IRQ_ENABLE = 8'h18;
  localparam logic [ADDR_W-1:0] ADR_DREG_BASE = 8'h40;
  localparam logic [ADDR_W-1:0] ADR_DREG_LAST = 8'h9c;

  // Interrupt events
  localparam int IRQ_N = 3;
  localparam int IRQ_DONE = 0;
  localparam int IRQ_OPERAND_ERROR_FLAG = 1;
  localparam int IRQ_INX = 2;

  typedef enum logic [1:0] {ST_IDLE = 2'b00, ST_EXEC = 2'b01, ST_DONE = 2'b11} fuc_state_type;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [WORD_W-1:0] wdata;
    logic wr;
    logic rd;
  } fuc_bus_req_type;

  typedef struct packed {
    logic valid;
    logic [WORD_W-1:0] word;
    logic [EXT_W-1:0] move_ext;
    logic [EXT_W-1:0] alu_ext;
  } fuc_instr_type;

endpackage : fuc_pkg

// File: hw/fuc_convert_unit.sv
// Float to unsigned integer conversion unit with data registers and flags
//
// The implementer's own choices: the register offsets and the strobed register port.
`timescale 1ns/1ns
module fuc_convert_unit
  import fuc_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic ce,
  input wire fuc_pkg::fuc_bus_req_type bus_req,
  output logic [fuc_pkg::WORD_W-1:0] bus_rdata,
  input wire fuc_pkg::fuc_instr_type instr,
  output logic instr_ready,
  output logic conv_done,
  output logic [fuc_pkg::WORD_W-1:0] conv_result,
  output logic [7:0] cond_code,
  output logic [7:0] exc_status,
  output logic [7:0] exc_accum,
  output logic irq
);

  import fuc_pkg::*;

  // ==========================================================================
  // Conversion result
  typedef struct packed {
    logic [WORD_W-1:0] res;
    logic ovf;
    logic zero;
    logic neg;
    logic inf;
    logic inexact_flag;
    logic signaling_nan_flag;
    logic nan_flag;
  } fuc_conv_type;

  typedef struct packed {
    fuc_state_type st;
    logic [7:0] cnt;
    logic [2:0] dst;
    logic trunc;
    logic [1:0] mode;
    logic [7:0] condition_code_byte;
    logic [7:0] er;
    logic [7:0] exception_flag_field;
    logic [IRQ_N-1:0] ist;
    logic [IRQ_N-1:0] ien;
    logic [WORD_W-1:0] rdata;
    logic [WORD_W-1:0] result;
    logic [NREG-1:0][NPART-1:0][WORD_W-1:0] dreg;
  } fuc_regs_type;

  fuc_regs_type state_reg;
  fuc_regs_type state_next;
  fuc_conv_type conv;
  logic [1:0] eff_mode;
  logic [2:0] dreg_num;
  logic [1:0] dreg_part;
  logic dreg_hit;

  // ==========================================================================
  // Operand class
  typedef struct packed {
    logic nan_flag;
    logic signaling_nan_flag;
    logic inf;
    logic zero;
  } fuc_class_type;

  function automatic fuc_class_type classify(
    input logic [EXP_W-1:0] ex,
    input logic [WORD_W-1:0] man
  );
    fuc_class_type k;
    k.nan_flag = (ex == EXP_ONES) && (man[QUIET_BIT:0] != '0);
    k.signaling_nan_flag = k.nan_flag && !man[QUIET_BIT];
    k.inf = (ex == EXP_ONES) && (man[QUIET_BIT:0] == '0);
    k.zero = (ex == '0) && (man == '0);
    return k;
  endfunction : classify

  // ==========================================================================
  // Data register address to register number and part
  function automatic logic [4:0] reg_slot(input logic [ADDR_W-1:0] a);
    logic [4:0] idx;
    logic [2:0] num;
    logic [1:0] part;
    idx = 5'((a - ADR_DREG_BASE) >> 2);
    num = 3'(idx / 5'd3);
    part = 2'(idx % 5'd3);
    return {num, part};
  endfunction : reg_slot

  // ==========================================================================
  // Condition byte update, untouched bits kept
  function automatic logic [7:0] cond_byte(input logic [7:0] old, input fuc_conv_type c);
    logic [7:0] b;
    b = old;
    b[CC_V] = c.ovf;
    b[CC_Z] = c.zero;
    b[CC_N] = c.neg;
    b[CC_I] = c.inf;
    return b;
  endfunction : cond_byte

  // ==========================================================================
  // New exception status byte
  function automatic logic [7:0] exc_byte(input fuc_conv_type c);
    logic [7:0] e;
    e = '0;
    e[EX_INX] = c.inexact_flag;
    e[EX_DZ] = 1'b0;
    e[EX_UNF] = 1'b0;
    e[EX_OVF] = 1'b0;
    e[EX_OPERAND_ERROR_FLAG] = c.ovf;
    e[EX_SIGNALING_NAN_FLAG] = c.signaling_nan_flag;
    e[EX_NAN] = c.nan_flag;
    e[EX_UNORDERED_FLAG] = 1'b0;
    return e;
  endfunction : exc_byte

  // ==========================================================================
  // Operand to unsigned integer
  function automatic fuc_conv_type convert(
    input logic [WORD_W-1:0] hi,
    input logic [WORD_W-1:0] man,
    input logic [1:0] mode
  );
    fuc_conv_type c;
    logic sgn;
    logic [EXP_W-1:0] ex;
    logic [EXP_W-1:0] ex_eff;
    logic is_nan;
    logic is_inf;
    logic is_zero;
    logic too_big;
    logic neg_nz;
    logic [12:0] sh;
    logic [95:0] wide;
    logic [WORD_W-1:0] ip;
    logic guard;
    logic sticky;
    logic inc;
    logic [WORD_W:0] sum;
    logic big_pos;
    fuc_class_type cls;
    sgn = hi[SIGN_BIT];
    ex = hi[EXP_W-1:0];
    ex_eff = (ex == '0) ? 11'h001 : ex;
    cls = classify(ex, man);
    is_nan = cls.nan_flag;
    is_inf = cls.inf;
    is_zero = cls.zero;
    too_big = ({2'b00, ex_eff} > SHIFT_BASE);
    sh = too_big ? 13'h0000 : (SHIFT_BASE - {2'b00, ex_eff});
    if (sh > SHIFT_MAX)
    begin
      ip = '0;
      guard = 1'b0;
      sticky = |man;
    end
    else
    begin
      wide = {man, 64'h0} >> sh[6:0];
      ip = wide[95:64];
      guard = wide[63];
      sticky = |wide[62:0];
    end
    case (mode)
      RM_NEAREST: inc = guard & (sticky | ip[0]);
      RM_ZERO: inc = 1'b0;
      RM_MINUS: inc = sgn & (guard | sticky);
      RM_PLUS: inc = ~sgn & (guard | sticky);
      default: inc = 1'b0;
    endcase
    sum = {1'b0, ip} + {{WORD_W{1'b0}}, inc};
    neg_nz = sgn & ~is_zero & ~is_nan;
    big_pos = ~sgn & ~is_nan & ~is_inf & (too_big | (sum > {1'b0, RES_POS_MAX}));
    if (is_nan)
      c.res = RES_NAN;
    else if (is_inf)
      c.res = sgn ? RES_NEG_LIM : RES_POS_MAX;
    else if (is_zero)
      c.res = RES_ZERO;
    else if (neg_nz)
      c.res = RES_NEG_LIM;
    else if (big_pos)
      c.res = RES_POS_MAX;
    else
      c.res = sum[WORD_W-1:0];
    c.ovf = is_nan | is_inf | neg_nz | big_pos;
    c.zero = (c.res == '0);
    c.neg = sgn & ~is_nan;
    c.inf = is_inf;
    c.inexact_flag = is_nan | is_inf | neg_nz | big_pos | guard | sticky;
    c.signaling_nan_flag = cls.signaling_nan_flag;
    c.nan_flag = is_nan;
    return c;
  endfunction : convert

  // ==========================================================================
  // Instruction decode
  function automatic logic [1:0] decode_kind(input logic [WORD_W-1:0] w);
    logic [1:0] k;
    k = 2'b00;
    if ((w[13:8] == OPC_HIGH) && (w[3] == 1'b0))
    begin
      if (w[5:4] == OPC_ROUND)
        k = 2'b01;
      else if (w[5:4] == OPC_TRUNC)
        k = 2'b10;
    end
    return k;
  endfunction : decode_kind

  assign eff_mode = state_reg.trunc ? RM_ZERO : state_reg.mode;
  assign conv = convert(state_reg.dreg[state_reg.dst][2], state_reg.dreg[state_reg.dst][1], eff_mode);
  assign {dreg_num, dreg_part} = reg_slot(bus_req.addr);
  assign dreg_hit = (bus_req.addr >= ADR_DREG_BASE) && (bus_req.addr <= ADR_DREG_LAST)
    && (bus_req.addr[1:0] == 2'b00);

  // ==========================================================================
  // Next state
  always_comb
  begin
    logic [1:0] kind;
    logic [7:0] ex_new;
    logic [IRQ_N-1:0] ev;
    logic [IRQ_N-1:0] clr;
    kind = decode_kind(instr.word);
    ex_new = '0;
    ev = '0;
    clr = '0;
    state_next = state_reg;
    state_next.rdata = '0;
    // Register writes
    if (bus_req.wr)
    begin
      case (bus_req.addr)
        ADR_STATUS_WORD: state_next.mode = bus_req.wdata[1:0];
        ADR_COND: state_next.condition_code_byte = bus_req.wdata[7:0];
        ADR_EXC_ACC: state_next.exception_flag_field = bus_req.wdata[7:0];
        ADR_IRQ_CLEAR: clr = bus_req.wdata[IRQ_N-1:0];
        ADR_IRQ_ENABLE: state_next.ien = bus_req.wdata[IRQ_N-1:0];
        default:
        begin
          if (dreg_hit)
            state_next.dreg[dreg_num][dreg_part] = bus_req.wdata;
        end
      endcase
    end
    // Register reads
    if (bus_req.rd)
    begin
      case (bus_req.addr)
        ADR_STATUS_WORD: state_next.rdata = {30'h0, state_reg.mode};
        ADR_COND: state_next.rdata = {24'h0, state_reg.condition_code_byte};
        ADR_EXC: state_next.rdata = {24'h0, state_reg.er};
        ADR_EXC_ACC: state_next.rdata = {24'h0, state_reg.exception_flag_field};
        ADR_IRQ_STATUS: state_next.rdata = {29'h0, state_reg.ist};
        ADR_IRQ_ENABLE: state_next.rdata = {29'h0, state_reg.ien};
        default:
        begin
          if (dreg_hit)
            state_next.rdata = state_reg.dreg[dreg_num][dreg_part];
        end
      endcase
    end
    // Sequencer
    case (state_reg.st)
      ST_IDLE:
      begin
        if (instr.valid && (kind != 2'b00))
        begin
          state_next.st = ST_EXEC;
          state_next.dst = instr.word[2:0];
          state_next.trunc = kind[1];
          state_next.cnt = BASE_CYCLES + {4'h0, instr.move_ext} + {4'h0, instr.alu_ext};
        end
      end
      ST_EXEC:
      begin
        state_next.cnt = state_reg.cnt - 8'h01;
        if (state_reg.cnt == 8'h01)
        begin
          state_next.st = ST_DONE;
          state_next.result = conv.res;
          state_next.dreg[state_reg.dst][0] = conv.res;
          state_next.condition_code_byte = cond_byte(state_next.condition_code_byte, conv);
          ex_new = exc_byte(conv);
          state_next.er = ex_new;
          state_next.exception_flag_field = state_next.exception_flag_field | ex_new;
          ev[IRQ_DONE] = 1'b1;
          ev[IRQ_OPERAND_ERROR_FLAG] = conv.ovf;
          ev[IRQ_INX] = conv.inexact_flag;
        end
      end
      ST_DONE:
      begin
        state_next.st = ST_IDLE;
      end
      default:
      begin
        state_next.st = ST_IDLE;
      end
    endcase
    // Sticky interrupt status, a new event wins over a clear
    state_next.ist = (state_reg.ist & ~clr) | ev;
  end

  // ==========================================================================
  // State register
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_reg <= '0;
    end
    else if (ce)
    begin
      state_reg <= state_next;
    end
  end

  // ==========================================================================
  // Outputs
  assign bus_rdata = state_reg.rdata;
  assign instr_ready = (state_reg.st == ST_IDLE);
  assign conv_done = (state_reg.st == ST_DONE);
  assign conv_result = state_reg.result;
  assign cond_code = state_reg.condition_code_byte;
  assign exc_status = state_reg.er;
  assign exc_accum = state_reg.exception_flag_field;
  assign irq = |(state_reg.ist & state_reg.ien);

endmodule : fuc_convert_unit

// File: sim/fuc_convert_unit_sva.sv
// Port assertions for the conversion unit
`timescale 1ns/1ns
module fuc_convert_unit_sva
  import fuc_pkg::*;
(
  input logic clk_sys,
  input logic rst_n,
  input logic ce,
  input fuc_pkg::fuc_instr_type instr,
  input logic instr_ready,
  input logic conv_done,
  input logic [fuc_pkg::WORD_W-1:0] conv_result,
  input logic [7:0] cond_code,
  input logic [7:0] exc_status,
  input logic [7:0] exc_accum
);
  // ==========================================================================
  // Accepted issue
  logic take;
  assign take = ce && instr_ready && instr.valid && instr.word[13:8] == OPC_HIGH && !instr.word[3]
    && (instr.word[5:4] == OPC_ROUND || instr.word[5:4] == OPC_TRUNC);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);
  // ==========================================================================
  // Properties
  property p_latency;
    take && instr.move_ext == 4'h0 && instr.alu_ext == 4'h0 |=> !instr_ready [*2] ##1 conv_done;
  endproperty
  a_latency: assert property (p_latency) else $error("conversion latency wrong");
  property p_ignore;
    ce && instr_ready && instr.valid && instr.word[13:8] != OPC_HIGH |=> instr_ready;
  endproperty
  a_ignore: assert property (p_ignore) else $error("foreign word accepted");
  property p_pulse;
    conv_done && ce |=> !conv_done && instr_ready;
  endproperty
  a_pulse: assert property (p_pulse) else $error("done pulse or ready wrong");
  property p_clear;
    conv_done |-> !exc_status[EX_DZ] && !exc_status[EX_UNF] && !exc_status[EX_OVF] && !exc_status[EX_UNORDERED_FLAG];
  endproperty
  a_clear: assert property (p_clear) else $error("cleared exception set");
  property p_zero;
    conv_done |-> cond_code[CC_Z] == (conv_result == RES_ZERO);
  endproperty
  a_zero: assert property (p_zero) else $error("zero code wrong");
  property p_operand_error_flag;
    conv_done |-> exc_status[EX_OPERAND_ERROR_FLAG] == cond_code[CC_V];
  endproperty
  a_operand_error_flag: assert property (p_operand_error_flag) else $error("operand error and overflow differ");
  property p_nan;
    conv_done && exc_status[EX_NAN] |-> conv_result == RES_NAN && cond_code[CC_V];
  endproperty
  a_nan: assert property (p_nan) else $error("nan result wrong");
  property p_signaling_nan_flag;
    conv_done && exc_status[EX_SIGNALING_NAN_FLAG] |-> exc_status[EX_NAN];
  endproperty
  a_signaling_nan_flag: assert property (p_signaling_nan_flag) else $error("signaling nan without nan");
  property p_inf;
    conv_done && cond_code[CC_I] |-> conv_result == (cond_code[CC_N] ? RES_NEG_LIM : RES_POS_MAX);
  endproperty
  a_inf: assert property (p_inf) else $error("infinity result wrong");
  property p_accum;
    conv_done |-> (exc_accum & exc_status) == exc_status;
  endproperty
  a_accum: assert property (p_accum) else $error("accumulated field missing bits");
endmodule : fuc_convert_unit_sva

bind fuc_convert_unit fuc_convert_unit_sva fuc_convert_unit_sva_inst (.clk_sys, .rst_n, .ce, .instr,
  .instr_ready, .conv_done, .conv_result, .cond_code, .exc_status, .exc_accum);

// File: sim/tb_top.sv
// Self-checking bench for the conversion unit
`timescale 1ns/1ns
module tb_top;
  import fuc_pkg::*;
  typedef struct packed {logic [11:0] hi; logic [31:0] mid; logic [1:0] mode; logic tr;
    logic [31:0] res; logic [7:0] cc; logic [7:0] ex;} fuc_vec_type;
  logic clk_sys, rst_n, ce, instr_ready, conv_done, irq;
  fuc_bus_req_type bus_req;
  fuc_instr_type instr;
  logic [31:0] bus_rdata, conv_result, rd_d;
  logic [7:0] cond_code, exc_status, exc_accum, acc;
  int errors, num_checks;
  fuc_vec_type vt [16];
  fuc_convert_unit fuc_convert_unit_inst (.clk_sys, .rst_n, .ce, .bus_req, .bus_rdata, .instr, .instr_ready,
    .conv_done, .conv_result, .cond_code, .exc_status, .exc_accum, .irq);
  // ==========================================================================
  // Shared tasks
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    bus_req <= '{a, d, 1'b1, 1'b0};
    @(posedge clk_sys);
    bus_req.wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_sys);
    bus_req <= '{a, 32'h0, 1'b0, 1'b1};
    @(posedge clk_sys);
    bus_req.rd <= 1'b0;
    @(negedge clk_sys);
    d = bus_rdata;
  endtask : rd
  task automatic conv(input fuc_vec_type v, input int n, input int mv, input int da);
    logic [7:0] base;
    int cnt;
    base = 8'h40 + 8'(12 * n);
    wr(base + 8'h08, {20'h0, v.hi});
    wr(base + 8'h04, v.mid);
    wr(base, 32'h5a5a5a5a);
    wr(ADR_STATUS_WORD, {30'h0, v.mode});
    @(posedge clk_sys);
    instr <= '{1'b1, {18'h3ffff, 2'b10, 4'b0010, 2'b11, v.tr, 2'b00, 3'(n)}, 4'(mv), 4'(da)};
    @(posedge clk_sys);
    instr.valid <= 1'b0;
    cnt = 0;
    do
    begin
      @(negedge clk_sys);
      cnt++;
    end while (conv_done !== 1'b1 && cnt < 40);
    acc = acc | v.ex;
    chk("cycles", 32'(int'(BASE_CYCLES) + 1 + mv + da), 32'(cnt));
    chk("result", v.res, conv_result);
    chk("cond", {24'h0, v.cc | 8'he1}, {24'h0, cond_code});
    chk("exc", {24'h0, v.ex}, {24'h0, exc_status});
    chk("accum", {24'h0, acc}, {24'h0, exc_accum});
    rd(base, rd_d);
    chk("low", v.res, rd_d);
    rd(base + 8'h04, rd_d);
    chk("mid", v.mid, rd_d);
    rd(base + 8'h08, rd_d);
    chk("high", {20'h0, v.hi}, rd_d);
  endtask : conv
  // ==========================================================================
  // Scenarios
  task automatic t_convert();
    for (int i = 0; i < 16; i++)
      conv(vt[i], i % 8, i % 3, i % 2);
  endtask : t_convert
  task automatic t_decode();
    for (int i = 0; i < 2; i++)
    begin
      @(posedge clk_sys);
      instr <= '{1'b1, i == 0 ? 32'h00002300 : 32'h00002230, 4'h0, 4'h0};
      @(posedge clk_sys);
      instr.valid <= 1'b0;
      repeat (4) @(negedge clk_sys);
      chk("ignored", 32'h1, {31'h0, instr_ready & ~conv_done});
    end
  endtask : t_decode
  task automatic t_irq();
    wr(ADR_IRQ_ENABLE, 32'h2);
    wr(ADR_IRQ_CLEAR, 32'h7);
    conv(vt[15], 0, 0, 0);
    chk("irq masked", 32'h0, {31'h0, irq});
    rd(ADR_IRQ_STATUS, rd_d);
    chk("irq status", 32'h5, rd_d);
    wr(ADR_IRQ_ENABLE, 32'h4);
    @(negedge clk_sys);
    chk("irq on", 32'h1, {31'h0, irq});
    wr(ADR_IRQ_CLEAR, 32'h4);
    @(negedge clk_sys);
    chk("irq off", 32'h0, {31'h0, irq});
  endtask : t_irq
  task automatic t_bus();
    rd(8'h3c, rd_d);
    chk("unmapped", 32'h0, rd_d);
    rd(ADR_IRQ_CLEAR, rd_d);
    chk("clear reg", 32'h0, rd_d);
    rd(ADR_EXC, rd_d);
    chk("exc reg", {24'h0, vt[15].ex}, rd_d);
  endtask : t_bus
  task automatic finish_test();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : finish_test
  // ==========================================================================
  // Clock, watchdog, main sequence
  initial
  begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  initial
  begin
    #2000000;
    errors++;
    finish_test();
  end
  initial
  begin
    rst_n = 1'b0;
    ce = 1'b1;
    bus_req = '0;
    instr = '0;
    errors = 0;
    num_checks = 0;
    acc = 8'h00;
    vt = '{'{12'h400, 32'ha0000000, 2'h0, 1'b0, 32'h2, 8'h00, 8'h01}, '{12'h3ff, 32'hc0000000, 2'h1, 1'b0, 32'h1,
      8'h00, 8'h01}, '{12'h3ff, 32'hc0000000, 2'h2, 1'b0, 32'h1, 8'h00, 8'h01},
      '{12'h3ff, 32'hc0000000, 2'h3, 1'b0, 32'h2, 8'h00, 8'h01}, '{12'h3ff, 32'hc0000000, 2'h3, 1'b1, 32'h1, 8'h00, 8'h01},
      '{12'h400, 32'hc0000000, 2'h0, 1'b0, 32'h3, 8'h00, 8'h00}, '{12'h7ff, 32'h80000000, 2'h0, 1'b0, RES_POS_MAX, 8'h12,
      8'h11}, '{12'hfff, 32'h80000000, 2'h0, 1'b0, RES_NEG_LIM, 8'h1a, 8'h11},
      '{12'h7ff, 32'hc0000000, 2'h0, 1'b0, RES_NAN, 8'h02, 8'h51}, '{12'h7ff, 32'ha0000000, 2'h0, 1'b1, RES_NAN, 8'h02, 8'h71},
      '{12'h000, 32'h0, 2'h0, 1'b0, 32'h0, 8'h04, 8'h00}, '{12'h800, 32'h0, 2'h0, 1'b1, 32'h0, 8'h0c, 8'h00},
      '{12'hbff, 32'h80000000, 2'h0, 1'b0, RES_NEG_LIM, 8'h0a, 8'h11}, '{12'h41e, 32'h80000000, 2'h0, 1'b0, RES_POS_MAX,
      8'h02, 8'h11}, '{12'h41d, 32'hfffffffe, 2'h0, 1'b1, RES_POS_MAX, 8'h00, 8'h00},
      '{12'h3fd, 32'h80000000, 2'h0, 1'b0, 32'h0, 8'h04, 8'h01}};
    repeat (16) @(posedge clk_sys);
    rst_n <= 1'b1;
    wr(ADR_COND, 32'he1);
    wr(ADR_EXC_ACC, 32'h0);
    t_convert();
    t_decode();
    t_irq();
    t_bus();
    finish_test();
  end
endmodule : tb_top
